// [tdm_parallel_access_core.sv]
// Purpose: Bridges two transmit and one receive TDM stream to a parallel bus
// Assumes: Bit clock is its own domain; parallel pins are asynchronous
// Notes:   Serial side writes the receive RAM, parallel side the transmit RAMs
//
// Overview of operation
// - Master select high forces microprocessor mode
// - Master low: sub select picks fast RAM/controller
// - Mode 1 sub select pin is vector acknowledge
// - Mode 3 drives address and control outputs
// - 32-channel: RAM byte n is channel n
// - 24-channel: skip every fourth channel, send ones
// - Mode 1 channel count from control bit
// - Modes 2, 3 channel count from pin
// - Each stream has its own 32-byte RAM
// - Contention only on same location, same time
// - Serial access in last half cycle of slot
// - Serial access wins; parallel access waits
// - Mode 1 contention withholds transfer acknowledge
// - Mode 2 window is last slot cycle; busy
// - Access ending early in window: no busy
// - Access running into serial access: busy; the core gives no busy if the access began before the window
// - Access inside window: busy until serial done
// - Mode 3 needs no contention arbitration
// - Mode 1 reaches all RAMs and registers
// - Acknowledge once read data valid or latched
// - Master select low pulse clears control registers
`default_nettype none
`timescale 1ns/1ps

module tdm_parallel_access_core
  import tdm_pac_pkg::*;
(
  // System clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  // Mode pins
  input  wire logic       MASTER_MODE_SELECT,
  input  wire logic       SUB_MODE_SELECT,
  input  wire logic       CH32_SELECT,
  // Parallel host strobes
  input  wire logic       CHIP_SELECT_N,
  input  wire logic       DATA_STROBE_N,
  input  wire logic       OUTPUT_ENABLE_N,
  input  wire logic       READ_WRITE,
  input  wire logic [5:0] ADDR,
  // Parallel data bus
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_N,
  // Transfer acknowledge or busy, open drain
  output logic            TRANSFER_ACK_OUT,
  output logic            TRANSFER_ACK_OE_N,
  // Bus controller outputs
  output logic      [4:0] BUS_ADDR,
  output logic            BUS_WE_N,
  output logic            BUS_CS_N,
  output logic            BUS_CTRL_OE_N,
  // Serial link
  input  wire logic       BIT_CLOCK_IN,
  input  wire logic       FRAME_PULSE_IN_N,
  input  wire logic       SERIAL_IN_STREAM,
  output logic            SERIAL_OUT_STREAM_A,
  output logic            SERIAL_OUT_STREAM_B,
  output logic            DELAYED_CS_N
);

  // Dual-port RAMs
  logic [7:0]     tx_ram_a [RAM_DEPTH];
  logic [7:0]     tx_ram_b [RAM_DEPTH];
  logic [7:0]     rx_ram   [RAM_DEPTH];

  // System-domain state
  pin_sample_t    pin_raw, sy1_reg, sy2_reg, sy3_reg, pin_reg, pin_next;
  logic           wsy1_reg, wsy2_reg, wsy3_reg, win_reg, win_next, win_prev_reg;
  state_t         state_reg, state_next;
  logic [1:0]     cyc_reg, cyc_next;
  logic [7:0]     d_out_reg, ctrl1_reg, ctrl2_reg, vect_reg;
  logic           ch24_reg, ch24_next, m3_vld_reg;
  logic [4:0]     m3_loc_reg;

  // Link-domain state
  logic           lrst1_reg, lrst2_reg, c24_1_reg, c24_2_reg, c24_3_reg, fp_reg, in_reg;
  frame_pos_t     pos_reg;
  serial_access_t sa_reg;
  logic [7:0]     rx_sh_reg, sh_a_reg, sh_b_reg;
  logic           dcs_n_reg;

  // Decode wires
  mode_t          mode;
  logic           m1, m2, m3, vec_fetch, req, is_read, ram_acc, reg_acc;
  logic           contention, do_acc, start_m3, win_fall, wr_reg, sel_b, wr_a, wr_b;
  logic           m3_latch, drive_data;
  logic [4:0]     loc, wr_loc;
  logic [7:0]     reg_data, rd_data, wr_data;

  // Mode decode from filtered pins
  assign mode = pin_reg.master_mode_select ? MODE_UP
              : (pin_reg.sub ? MODE_FAST_RAM : MODE_BUS_CTRL);
  assign m1 = (mode == MODE_UP);
  assign m2 = (mode == MODE_FAST_RAM);
  assign m3 = (mode == MODE_BUS_CTRL);

  // Host request decode; mode 3 never raises a host request
  assign vec_fetch = m1 & ~pin_reg.sub & ~pin_reg.ds_n;
  assign req = m1 ? ((~pin_reg.cs_n & ~pin_reg.ds_n) | vec_fetch)
             : (m2 & ~pin_reg.cs_n & (~pin_reg.oe_n | ~pin_reg.rw));
  assign is_read = pin_reg.rw;
  assign loc = pin_reg.addr[4:0];
  assign ram_acc = m2 | (m1 & ~vec_fetch & ~pin_reg.addr[RAM_SEL_BIT]);
  assign reg_acc = m1 & ~vec_fetch & pin_reg.addr[RAM_SEL_BIT];

  // Clash only with the serial access to the same byte inside the window
  assign contention = ram_acc & win_reg
                    & (is_read ? (sa_reg.rx_vld & (sa_reg.rx_loc == loc))
                               : (sa_reg.tx_vld & (sa_reg.tx_loc == loc)));
  assign do_acc = req & ~contention
                & ((state_reg == ST_IDLE) | (state_reg == ST_HOLD));
  assign win_fall = win_prev_reg & ~win_reg;
  assign start_m3 = m3 & win_fall & m3_vld_reg;

  // Read data selection
  assign reg_data = (pin_reg.addr == CTRL1_ADDR) ? ctrl1_reg
                  : (pin_reg.addr == CTRL2_ADDR) ? ctrl2_reg
                  : (pin_reg.addr == VECT_ADDR) ? vect_reg : REG_RESET;
  assign rd_data = vec_fetch ? vect_reg : (reg_acc ? reg_data : rx_ram[loc]);

  // Write steering to the transmit RAMs and registers
  assign wr_reg = do_acc & ~is_read & reg_acc;
  assign sel_b = m1 ? ctrl2_reg[TXB_SEL_BIT] : pin_reg.addr[RAM_SEL_BIT];
  assign m3_latch = (state_reg == ST_M3_IN) & (cyc_reg == M3_CYC);
  assign wr_a = (do_acc & ~is_read & ram_acc & ~sel_b) | m3_latch;
  assign wr_b = do_acc & ~is_read & ram_acc & sel_b;
  assign wr_loc = m3_latch ? m3_loc_reg : loc;
  assign wr_data = pin_reg.data;

  // Channel configuration per mode
  assign ch24_next = m1 ? ctrl1_reg[CH_COUNT_BIT] : ~pin_reg.ch32;

  // Three-stage pin filter: a change counts when stages two and three agree
  assign pin_raw = {MASTER_MODE_SELECT, SUB_MODE_SELECT, CH32_SELECT, CHIP_SELECT_N,
                    DATA_STROBE_N, OUTPUT_ENABLE_N, READ_WRITE, ADDR, DATA_IN};
  assign pin_next = (sy2_reg & sy3_reg) | (pin_reg & (sy2_reg ^ sy3_reg));
  assign win_next = (wsy2_reg == wsy3_reg) ? wsy3_reg : win_reg;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      sy1_reg <= PIN_IDLE;
      sy2_reg <= PIN_IDLE;
      sy3_reg <= PIN_IDLE;
      pin_reg <= PIN_IDLE;
      wsy1_reg <= 1'b0;
      wsy2_reg <= 1'b0;
      wsy3_reg <= 1'b0;
      win_reg <= 1'b0;
      win_prev_reg <= 1'b0;
    end
    else
    begin
      sy1_reg <= pin_raw;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      pin_reg <= pin_next;
      wsy1_reg <= sa_reg.win;
      wsy2_reg <= wsy1_reg;
      wsy3_reg <= wsy2_reg;
      win_reg <= win_next;
      win_prev_reg <= win_reg;
    end
  end

  // Access sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (start_m3)
          state_next = ST_M3_OUT;
        else if (req)
          state_next = contention ? ST_HOLD : ST_ACK;
      ST_HOLD:
        if (!req)
          state_next = ST_IDLE;
        else if (!contention)
          state_next = ST_ACK;
      ST_ACK:
        if (!req)
          state_next = ST_IDLE;
      ST_M3_OUT:
        if (cyc_reg == M3_CYC)
          state_next = ST_M3_IN;
      ST_M3_IN:
        if (cyc_reg == M3_CYC)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end
  assign cyc_next = (state_next != state_reg) ? 2'h0 : 2'(cyc_reg + CYC_ONE);

  // Sequencer, read data and mode 3 location
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= ST_IDLE;
      cyc_reg <= 2'h0;
      d_out_reg <= REG_RESET;
      ch24_reg <= 1'b0;
      m3_loc_reg <= 5'h00;
      m3_vld_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      ch24_reg <= ch24_next;
      if (do_acc & is_read)
        d_out_reg <= rd_data;
      else if (start_m3)
        d_out_reg <= rx_ram[m3_loc_reg];
      if (win_reg)
      begin
        m3_loc_reg <= sa_reg.rx_loc;
        m3_vld_reg <= sa_reg.rx_vld;
      end
    end
  end

  // Mode 1 control registers, cleared while master select is low
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl1_reg <= REG_RESET;
      ctrl2_reg <= REG_RESET;
      vect_reg <= REG_RESET;
    end
    else if (!pin_reg.master_mode_select)
    begin
      ctrl1_reg <= REG_RESET;
      ctrl2_reg <= REG_RESET;
      vect_reg <= REG_RESET;
    end
    else if (wr_reg)
    begin
      if (pin_reg.addr == CTRL1_ADDR)
        ctrl1_reg <= wr_data;
      if (pin_reg.addr == CTRL2_ADDR)
        ctrl2_reg <= wr_data;
      if (pin_reg.addr == VECT_ADDR)
        vect_reg <= wr_data;
    end
  end

  // Transmit RAM write port
  always_ff @(posedge CLK_SYS)
  begin
    if (wr_a)
      tx_ram_a[wr_loc] <= wr_data;
    if (wr_b)
      tx_ram_b[wr_loc] <= wr_data;
  end

  // Parallel pin drive
  assign drive_data = ((state_reg == ST_ACK) & is_read & req) | (state_reg == ST_M3_OUT);
  assign DATA_OUT = d_out_reg;
  assign DATA_OE_N = ~drive_data;
  assign TRANSFER_ACK_OUT = 1'b0;
  assign TRANSFER_ACK_OE_N = ~((m1 & (state_reg == ST_ACK))
                           | (m2 & (state_reg == ST_HOLD)));
  assign BUS_ADDR = m3_loc_reg;
  assign BUS_WE_N = ~(state_reg == ST_M3_OUT);
  assign BUS_CS_N = ~((state_reg == ST_M3_OUT) | (state_reg == ST_M3_IN));
  assign BUS_CTRL_OE_N = ~m3;

  // Channel to RAM location map; top bit marks a used channel
  function automatic logic [5:0] map_loc(input logic [4:0] ch, input logic c24);
    logic [4:0] grp;
    logic [4:0] pos;
    begin
      grp = {2'b00, ch[4:2]};
      pos = grp + {grp[3:0], 1'b0} + {3'b000, ch[1:0]} - LOC_ONE;
      if (!c24)
        map_loc = {1'b1, ch};
      else
        map_loc = {(ch[1:0] != 2'b00), pos};
    end
  endfunction : map_loc

  // Link-domain wires
  logic [5:0]     cur_map;
  logic [5:0]     nxt_map;
  logic [4:0]     nxt_slot;
  logic           lrst_n;
  logic           odd_phase;
  logic           at_access;
  logic [7:0]     rx_byte;

  assign lrst_n = lrst2_reg;
  assign nxt_slot = 5'(pos_reg.slot + LOC_ONE);
  assign cur_map = map_loc(pos_reg.slot, c24_3_reg);
  assign nxt_map = map_loc(nxt_slot, c24_3_reg);
  assign odd_phase = pos_reg.phase[0];
  assign at_access = (pos_reg.phase == ACCESS_PHASE);
  assign rx_byte = {rx_sh_reg[6:0], in_reg};

  // Reset release crossing into the link domain
  always_ff @(posedge BIT_CLOCK_IN or negedge NRST)
  begin
    if (!NRST)
    begin
      lrst1_reg <= 1'b0;
      lrst2_reg <= 1'b0;
    end
    else
    begin
      lrst1_reg <= 1'b1;
      lrst2_reg <= lrst1_reg;
    end
  end

  // Frame counter, published access and serial shifters
  always_ff @(posedge BIT_CLOCK_IN or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      c24_1_reg <= 1'b0;
      c24_2_reg <= 1'b0;
      c24_3_reg <= 1'b0;
      fp_reg <= 1'b1;
      in_reg <= 1'b1;
      pos_reg <= '0;
      sa_reg <= SA_IDLE;
      rx_sh_reg <= IDLE_BYTE;
      sh_a_reg <= IDLE_BYTE;
      sh_b_reg <= IDLE_BYTE;
      dcs_n_reg <= 1'b1;
    end
    else
    begin
      c24_1_reg <= ch24_reg;
      c24_2_reg <= c24_1_reg;
      fp_reg <= FRAME_PULSE_IN_N;
      in_reg <= SERIAL_IN_STREAM;
      pos_reg <= fp_reg ? frame_pos_t'(pos_reg + POS_ONE) : '0;
      sa_reg.win <= (pos_reg.phase == WIN_START_PHASE);
      if (pos_reg.phase == LOC_PHASE)
      begin
        sa_reg.rx_vld <= cur_map[5];
        sa_reg.rx_loc <= cur_map[4:0];
        sa_reg.tx_vld <= nxt_map[5];
        sa_reg.tx_loc <= nxt_map[4:0];
      end
      if (odd_phase)
        rx_sh_reg <= rx_byte;
      if (at_access)
      begin
        c24_3_reg <= c24_2_reg;                                       // Slot-aligned, no cut select
        sh_a_reg <= sa_reg.tx_vld ? tx_ram_a[sa_reg.tx_loc] : IDLE_BYTE;
        sh_b_reg <= sa_reg.tx_vld ? tx_ram_b[sa_reg.tx_loc] : IDLE_BYTE;
      end
      else if (odd_phase)
      begin
        sh_a_reg <= {sh_a_reg[6:0], 1'b1};
        sh_b_reg <= {sh_b_reg[6:0], 1'b1};
      end
      dcs_n_reg <= ~(cur_map[5] & (pos_reg.phase >= DCS_START_PHASE)
                   & (pos_reg.phase <= DCS_END_PHASE));
    end
  end

  // Receive RAM write port
  always_ff @(posedge BIT_CLOCK_IN)
  begin
    if (at_access & sa_reg.rx_vld)
      rx_ram[sa_reg.rx_loc] <= rx_byte;
  end

  // Serial outputs
  assign SERIAL_OUT_STREAM_A = sh_a_reg[7];
  assign SERIAL_OUT_STREAM_B = sh_b_reg[7];
  assign DELAYED_CS_N = dcs_n_reg;

endmodule : tdm_parallel_access_core

`default_nettype wire

// [tdm_pac_pkg.sv]
// Purpose: Shared constants and types for the TDM parallel access core
// Assumes: 32 timeslots of 16 bit-clock cycles per frame
// Notes:   Mode 1 register offsets are six-bit parallel addresses
`default_nettype none

package tdm_pac_pkg;

  // Operating modes and access sequencer states
  typedef enum logic [1:0] {MODE_UP, MODE_FAST_RAM, MODE_BUS_CTRL} mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_ACK, ST_M3_OUT, ST_M3_IN} state_t;

  // Asynchronous parallel-side pins, sampled as one word
  typedef struct packed {
    logic       master_mode_select;
    logic       sub;
    logic       ch32;
    logic       cs_n;
    logic       ds_n;
    logic       oe_n;
    logic       rw;
    logic [5:0] addr;
    logic [7:0] data;
  } pin_sample_t;

  // Serial-side access published to the parallel side
  typedef struct packed {
    logic       win;
    logic       rx_vld;
    logic [4:0] rx_loc;
    logic       tx_vld;
    logic [4:0] tx_loc;
  } serial_access_t;

  // Frame position on the bit clock
  typedef struct packed {
    logic [4:0] slot;
    logic [3:0] phase;
  } frame_pos_t;

  localparam int unsigned RAM_DEPTH = 32;

  // Pin idle levels at reset
  localparam pin_sample_t PIN_IDLE = '{master_mode_select: 1'b1, sub: 1'b1, ch32: 1'b1, cs_n: 1'b1,
                                       ds_n: 1'b1, oe_n: 1'b1, rw: 1'b1,
                                       addr: 6'h00, data: 8'h00};
  localparam serial_access_t SA_IDLE = '{win: 1'b0, rx_vld: 1'b0, rx_loc: 5'h00,
                                         tx_vld: 1'b0, tx_loc: 5'h00};

  // Mode 1 register map
  localparam logic [5:0] CTRL1_ADDR   = 6'h20;
  localparam logic [5:0] CTRL2_ADDR   = 6'h21;
  localparam logic [5:0] VECT_ADDR    = 6'h22;
  localparam int unsigned CH_COUNT_BIT = 5;
  localparam int unsigned TXB_SEL_BIT  = 0;
  localparam int unsigned RAM_SEL_BIT  = 5;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;

  // Timeslot phases
  localparam logic [3:0] WIN_START_PHASE = 4'hE;
  localparam logic [3:0] ACCESS_PHASE    = 4'hF;
  localparam logic [3:0] LOC_PHASE       = 4'h8;
  localparam logic [3:0] DCS_START_PHASE = 4'h7;
  localparam logic [3:0] DCS_END_PHASE   = 4'hE;

  // Counters
  localparam logic [8:0] POS_ONE  = 9'h001;
  localparam logic [4:0] LOC_ONE  = 5'h01;
  localparam logic [1:0] M3_CYC   = 2'h3;
  localparam logic [1:0] CYC_ONE  = 2'h1;

endpackage : tdm_pac_pkg

`default_nettype wire

// [tdm_pac_sva.sv]
// Purpose: Port checks for the TDM parallel access core
// Assumes: Mode pins held for eight cycles have passed the pin filter
// Notes:   Bound to the core at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module tdm_pac_sva
  import tdm_pac_pkg::*;
(
  // Clocks and reset
  input  wire logic CLK_SYS,
  input  wire logic NRST,
  input  wire logic BIT_CLOCK_IN,
  // Host side
  input  wire logic MASTER_MODE_SELECT,
  input  wire logic SUB_MODE_SELECT,
  input  wire logic CHIP_SELECT_N,
  input  wire logic READ_WRITE,
  input  wire logic DATA_OE_N,
  input  wire logic TRANSFER_ACK_OE_N,
  // Bus controller and link
  input  wire logic BUS_WE_N,
  input  wire logic BUS_CS_N,
  input  wire logic BUS_CTRL_OE_N,
  input  wire logic DELAYED_CS_N
);

  // Mode decode seen at the bus controller outputs
  mode1_bus_off_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    MASTER_MODE_SELECT [*8] |-> BUS_CTRL_OE_N) else $error("bus outputs on in mode 1");
  mode2_bus_off_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (!MASTER_MODE_SELECT && SUB_MODE_SELECT) [*8] |-> BUS_CTRL_OE_N)
    else $error("bus outputs on in mode 2");
  mode3_bus_on_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (!MASTER_MODE_SELECT && !SUB_MODE_SELECT) [*8] |-> !BUS_CTRL_OE_N)
    else $error("bus outputs off in mode 3");

  // Host handshake follows chip select and direction
  ack_needs_cs_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !TRANSFER_ACK_OE_N |-> !$past(CHIP_SELECT_N, 4) || !$past(CHIP_SELECT_N, 5)
    || !$past(CHIP_SELECT_N, 6)) else $error("acknowledge without chip select");
  read_drive_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !DATA_OE_N && BUS_CTRL_OE_N |-> $past(READ_WRITE, 3)) else $error("data driven on write");

  // Bus controller cycle shape
  m3_we_cs_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !BUS_WE_N |-> !BUS_CS_N && !DATA_OE_N) else $error("write strobe without select");
  m3_cycle_len_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $fell(BUS_WE_N) |-> !BUS_WE_N [*4] ##1 (BUS_WE_N && !BUS_CS_N && DATA_OE_N) [*4])
    else $error("bus cycle length wrong");

  // Delayed select spans the last eight bit clocks of a slot
  dcs_pulse_a: assert property (@(posedge BIT_CLOCK_IN) disable iff (!NRST)
    $fell(DELAYED_CS_N) |-> !DELAYED_CS_N [*8] ##1 DELAYED_CS_N)
    else $error("delayed select length wrong");

endmodule : tdm_pac_sva

bind tdm_parallel_access_core tdm_pac_sva u_sva (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .BIT_CLOCK_IN(BIT_CLOCK_IN), .MASTER_MODE_SELECT(MASTER_MODE_SELECT),
  .SUB_MODE_SELECT(SUB_MODE_SELECT), .CHIP_SELECT_N(CHIP_SELECT_N),
  .READ_WRITE(READ_WRITE), .DATA_OE_N(DATA_OE_N), .TRANSFER_ACK_OE_N(TRANSFER_ACK_OE_N),
  .BUS_WE_N(BUS_WE_N), .BUS_CS_N(BUS_CS_N), .BUS_CTRL_OE_N(BUS_CTRL_OE_N),
  .DELAYED_CS_N(DELAYED_CS_N));

`default_nettype wire

// [tdm_trunk_model.sv]
// Purpose: Trunk-side model feeding and capturing the serial streams
// Assumes: Frames run back to back on a free-running link clock
// Notes:   Slot n carries byte {3'h5, n}; captures hold the latest frame
`timescale 1ns/1ps
`default_nettype none

module tdm_trunk_model
(
  // Link clock and streams from the core
  input  wire logic bclk,
  input  wire logic sout_a,
  input  wire logic sout_b,
  // Frame pulse and stream to the core
  output logic      frame_n,
  output logic      sin
);
  logic [8:0] pos_reg = 9'h1FA; // First frame pulse lands just after link reset release
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic [7:0] cap_a [32];
  logic [7:0] cap_b [32];
  wire  [3:0] ph       = pos_reg[3:0];
  wire  [7:0] byte_out = {3'h5, pos_reg[8:4]};

  // Idle levels before the first link edge
  initial
  begin
    frame_n = 1'b1;
    sin     = 1'b1;
  end

  // Slot position; each transmit bit taken on its second clock
  always @(posedge bclk)
  begin
    pos_reg <= pos_reg + 9'h001;
    if (ph[0])
    begin
      sh_a <= {sh_a[6:0], sout_a};
      sh_b <= {sh_b[6:0], sout_b};
    end
    if (ph == 4'hF)
    begin
      cap_a[pos_reg[8:4]] <= {sh_a[6:0], sout_a};
      cap_b[pos_reg[8:4]] <= {sh_b[6:0], sout_b};
    end
  end

  // Frame pulse one clock before slot 0; bit 7 first, two clocks a bit
  always @(negedge bclk)
  begin
    frame_n <= (pos_reg != 9'h1FE);
    sin     <= byte_out[3'h7 - ph[3:1]];
  end

endmodule : tdm_trunk_model

`default_nettype wire

// [tb_tdm_parallel_access_core.sv]
// Purpose: Self-checking bench for the TDM parallel access core
// Assumes: Link clock of 80 ns, unrelated to the 10 ns system clock
// Notes:   Serial bytes are judged from the trunk model captures
`timescale 1ns/1ps
`default_nettype none

module tb_tdm_parallel_access_core
  import tdm_pac_pkg::*;
;
  logic       clk_sys, nrst, bclk, master_mode_select, sub, ch32, cs_n, ds_n, oe_n, rw;
  logic       data_oe_n, ack_oe_n, bus_oe_n, bus_cs_n, frame_n, sin, so_a, so_b;
  logic [5:0] addr;
  logic [4:0] loc, bus_addr;
  logic [7:0] din, dout, rd, vb;
  logic [7:0] mem_a [32];
  int         err_count, samples_checked, cyc;

  // System clock, then link clock out of phase with it
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    bclk = 1'b0;
    #3;
    forever #40 bclk = ~bclk;
  end

  tdm_parallel_access_core u_dut (.CLK_SYS(clk_sys), .NRST(nrst), .MASTER_MODE_SELECT(master_mode_select),
    .SUB_MODE_SELECT(sub), .CH32_SELECT(ch32), .CHIP_SELECT_N(cs_n), .DATA_STROBE_N(ds_n),
    .OUTPUT_ENABLE_N(oe_n), .READ_WRITE(rw), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_N(data_oe_n), .TRANSFER_ACK_OUT(), .TRANSFER_ACK_OE_N(ack_oe_n),
    .BUS_ADDR(bus_addr), .BUS_WE_N(), .BUS_CS_N(bus_cs_n), .BUS_CTRL_OE_N(bus_oe_n),
    .BIT_CLOCK_IN(bclk),
    .FRAME_PULSE_IN_N(frame_n), .SERIAL_IN_STREAM(sin), .SERIAL_OUT_STREAM_A(so_a),
    .SERIAL_OUT_STREAM_B(so_b), .DELAYED_CS_N());

  tdm_trunk_model u_far (.bclk(bclk), .sout_a(so_a), .sout_b(so_b), .frame_n(frame_n),
    .sin(sin));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Counts and verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // One host access; m1 picks strobe and acknowledge, else RAM style with busy
  task automatic acc(input logic m1, input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {cs_n, ds_n, oe_n, rw} <= {1'b0, ~m1, m1 | wr, ~wr};
    addr <= a;
    din  <= d;
    repeat (6) @(posedge clk_sys);
    while ((m1 ? ack_oe_n : !ack_oe_n) && n < 300)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (!m1)
      repeat (3) @(posedge clk_sys);
    check({7'h00, n < 300}, 8'h01);
    rd = dout;
    {cs_n, ds_n, oe_n, rw} <= 4'hF;
    repeat (8) @(posedge clk_sys);
  endtask : acc

  task automatic frames(input int n);
    repeat (n * 4200) @(posedge clk_sys);
  endtask : frames

  // Transmit byte expected on a channel, skipped channels all ones
  function automatic logic [7:0] exp_tx(input int c, input logic ch24);
    if (ch24 && c % 4 == 0)
      return IDLE_BYTE;
    return mem_a[ch24 ? c - c / 4 - 1 : c];
  endfunction : exp_tx

  task automatic chk_frame(input logic ch24);
    for (int c = 0; c < 32; c++)
      check(u_far.cap_a[c], exp_tx(c, ch24));
  endtask : chk_frame

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    {master_mode_select, sub, ch32, cs_n, ds_n, oe_n, rw} = 7'h7F;
    addr = 6'h00;
    din = 8'h00;
    void'($urandom(89));
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 32; i++)
    begin
      mem_a[i] = 8'($urandom);
      acc(1'b1, 1'b1, 6'(i), mem_a[i]);
    end
    frames(2);
    chk_frame(1'b0);
    for (int j = 0; j < 3; j++)
    begin
      loc = (j == 0) ? 5'h00 : (j == 1) ? 5'h1F : 5'($urandom_range(30, 1));
      acc(1'b1, 1'b0, {1'b0, loc}, 8'h00);
      check(rd, {3'h5, loc});
    end
    $display("mode 1 32-channel test done");
    acc(1'b1, 1'b1, CTRL1_ADDR, 8'h20);
    acc(1'b1, 1'b0, CTRL1_ADDR, 8'h00);
    check(rd, 8'h20);
    acc(1'b1, 1'b0, 6'h3F, 8'h00);
    check(rd, 8'h00);
    vb = 8'($urandom);
    acc(1'b1, 1'b1, VECT_ADDR, vb);
    sub <= 1'b0;
    acc(1'b1, 1'b0, 6'h00, 8'h00);
    check(rd, vb);
    sub <= 1'b1;
    frames(2);
    chk_frame(1'b1);
    master_mode_select <= 1'b0;
    repeat (10) @(posedge clk_sys);
    master_mode_select <= 1'b1;
    repeat (10) @(posedge clk_sys);
    acc(1'b1, 1'b0, CTRL1_ADDR, 8'h00);
    check(rd, REG_RESET);
    $display("mode 1 24-channel and clear test done");
    ch32 <= 1'b0;
    master_mode_select  <= 1'b0;
    repeat (10) @(posedge clk_sys);
    for (int j = 0; j < 24; j++)
    begin
      mem_a[j] = 8'($urandom);
      acc(1'b0, 1'b1, 6'(j), mem_a[j]);
    end
    vb = 8'($urandom);
    acc(1'b0, 1'b1, 6'h22, vb);
    frames(2);
    chk_frame(1'b1);
    check(u_far.cap_b[3], vb);
    loc = 5'($urandom_range(23, 0));
    acc(1'b0, 1'b0, {1'b0, loc}, 8'h00);
    check(rd, {3'h5, 5'(loc + loc / 3 + 1)});
    $display("mode 2 test done");
    din  <= 8'($urandom);
    ch32 <= 1'b1;
    sub  <= 1'b0;
    frames(3);
    check({7'h00, bus_oe_n}, 8'h00);
    check(u_far.cap_a[0], din);
    check(u_far.cap_a[31], din);
    @(negedge bus_cs_n);
    check({3'h0, bus_addr}, {3'h0, 5'(u_far.pos_reg[8:4] - 5'h01)});
    $display("mode 3 test done");
    end_of_test();
  end

endmodule : tb_tdm_parallel_access_core

`default_nettype wire
